// File: rtl/cam_back_pkg.sv
package cam_back_pkg;
  // ==========================================================
  // timing
  // ==========================================================
  localparam int unsigned CLK_MHZ      = 250;  // system clock rate
  localparam int unsigned DEBOUNCE_US  = 1;    // input settle time
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;  // 250 cycles
  localparam int unsigned DB_W         = 9;    // debounce counter width
  localparam int unsigned N_IN         = 9;    // debounced inputs
  // ==========================================================
  // input vector positions
  // ==========================================================
  localparam int unsigned IN_DOOR  = 0;
  localparam int unsigned IN_SYNC  = 1;
  localparam int unsigned IN_PERF  = 2;
  localparam int unsigned IN_PWR   = 3;
  localparam int unsigned IN_CODE0 = 4;  // code bits 4..8
  localparam int unsigned CODE_W   = 5;
  // pins held high by pull-ups when nothing drives them: door and sync contact
  localparam logic [N_IN-1:0] IN_IDLE = 9'h003;
  // ==========================================================
  // film codes
  // ==========================================================
  localparam logic [4:0] CODE_NONE    = 5'h00;
  localparam logic [4:0] CODE_PACK    = 5'h01;
  localparam logic [4:0] CODE_AUTO    = 5'h02;
  localparam logic [4:0] CODE_4X5     = 5'h03;
  localparam logic [4:0] CODE_6X7     = 5'h04;
  localparam logic [4:0] CODE_RSVD_A  = 5'h05;
  localparam logic [4:0] CODE_RSVD_B  = 5'h06;
  localparam logic [4:0] CODE_GENERIC = 5'h07;
  // ==========================================================
  // back types
  // ==========================================================
  typedef enum logic [2:0] {
    BACK_35MM, BACK_PACK, BACK_AUTO, BACK_4X5, BACK_6X7, BACK_GENERIC, BACK_RESERVED
  } back_type_t;
  // motor direction command
  typedef enum logic [1:0] {
    MOTOR_OFF, MOTOR_WIND, MOTOR_REWIND
  } motor_cmd_t;
endpackage

// File: rtl/debounce_if.sv
`timescale 1ns/1ns
// ==========================================================
// raw and settled input levels between top and filter bank
// ==========================================================
interface debounce_if;
  import cam_back_pkg::*;
  logic [N_IN-1:0] raw;     // already two-flop synchronised
  logic [N_IN-1:0] stable;  // settled level
  logic [N_IN-1:0] change;  // one-cycle pulse on settle change
  modport filt (input raw, output stable, output change);
  modport user (output raw, input stable, input change);
endinterface

// File: rtl/debounce_bank.sv
`timescale 1ns/1ns
module debounce_bank
  import cam_back_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // levels
  debounce_if.filt  dbi
);
  import cam_back_pkg::*;
  typedef struct packed {
    logic [N_IN-1:0]          stable;
    logic [N_IN-1:0]          change;
    logic [N_IN-1:0][DB_W-1:0] cnt;
  } db_state_t;
  db_state_t st_r;   // registered state
  db_state_t st_nxt; // next state
  // ==========================================================
  // per-input settle counters
  // ==========================================================
  // a level must hold for the whole window before it is accepted
  always_comb begin
    st_nxt        = st_r;
    st_nxt.change = '0;
    for (int i = 0; i < N_IN; i++) begin
      if (dbi.raw[i] == st_r.stable[i]) begin
        st_nxt.cnt[i] = '0;  // no disagreement, restart window
      end else if (st_r.cnt[i] == DB_W'(DEBOUNCE_CYC - 1)) begin
        st_nxt.stable[i] = dbi.raw[i];
        st_nxt.change[i] = 1'b1;
        st_nxt.cnt[i]    = '0;
      end else begin
        st_nxt.cnt[i] = st_r.cnt[i] + DB_W'(1);
      end
    end
  end
  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      // settled levels start at the pins' idle levels, so no false change follows reset
      st_r        <= '0;
      st_r.stable <= IN_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign dbi.stable = st_r.stable;
  assign dbi.change = st_r.change;
endmodule

// File: rtl/camera_back_interface.sv
`timescale 1ns/1ns
module camera_back_interface
  import cam_back_pkg::*;
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  // firmware control
  input  wire logic                    shutter_open_req,
  input  wire logic                    shutter_close_req,
  input  wire cam_back_pkg::motor_cmd_t motor_cmd,
  input  wire logic                    perf_enable,
  // connector inputs
  input  wire logic                    door_switch_in,
  input  wire logic                    sync_contact_in,
  input  wire logic                    perf_sense_in,
  input  wire logic                    back_power_sense,
  input  wire logic                    film_code_bit0,
  input  wire logic                    film_code_bit1,
  input  wire logic                    film_code_bit2,
  input  wire logic                    film_code_bit3,
  input  wire logic                    film_code_bit4,
  // shutter outputs
  output logic                         shutter_hold_drive,
  output logic                         shutter_hold_oe,
  output logic                         shutter_actuate_drive,
  // motor bridge
  output logic                         film_wind_neg,
  output logic                         film_wind_pos,
  // perforation emitter
  output logic                         perf_emitter_anode,
  output logic                         perf_emitter_cathode,
  // status to firmware
  output logic                         door_closed,
  output logic                         sync_level,
  output logic                         perf_seen,
  output logic                         back_power_ok,
  output logic [CODE_W-1:0]            film_code,
  output cam_back_pkg::back_type_t     back_type,
  output logic                         shutter_busy,
  output logic                         door_event,
  output logic                         perf_event,
  output logic                         code_event,
  output logic                         power_event
);
  import cam_back_pkg::*;

  // shutter sequence states
  // idle: actuation high, hold line floating
  // pulse low: actuation has just gone low, give the back a cycle
  // wait sync low: contact closing means the blades have opened
  // wait sync high: hold line now keeps the shutter open
  // hold: open until firmware asks for a close
  typedef enum logic [2:0] {
    SH_IDLE, SH_PULSE_LOW, SH_WAIT_SYNC_LOW, SH_WAIT_SYNC_HIGH, SH_HOLD
  } shutter_state_t;

  // all registered state of this module
  // one struct keeps reset and register update in a single place;
  // the outputs other than the constant hold pin value are plain fields of it, so each leaves a flop
  typedef struct packed {
    logic [N_IN-1:0]   sync1;    // first synchroniser stage
    logic [N_IN-1:0]   sync2;    // second synchroniser stage
    shutter_state_t    sh;
    logic              hold_oe;
    logic              actuate;
    logic              wind_neg;
    logic              wind_pos;
    logic              led_a;
    logic              led_k;
    logic              door;
    logic              syncl;
    logic              perf;
    logic              pwr;
    logic [CODE_W-1:0] code;
    back_type_t        btype;
    logic              busy;
    logic              ev_door;
    logic              ev_perf;
    logic              ev_code;
    logic              ev_pwr;
  } cb_state_t;

  cb_state_t st_r;   // registered state
  cb_state_t st_nxt; // next state

  // the filter bank sees the second synchroniser stage only
  // and hands back settled levels and one-cycle change pulses
  debounce_if dbi ();  // link to the filter bank

  // ==========================================================
  // decode of film code to camera back type
  // ==========================================================
  // unlisted codes are film speed codes, hence a 35mm back
  // codes five and six are kept apart so firmware can refuse them
  // rather than mistake a future back for a 35mm one
  // kept as a function so the type decode lives in one place
  function automatic back_type_t decode_back(input logic [CODE_W-1:0] c);
    back_type_t t;
    t = BACK_35MM;
    case (c)
      CODE_PACK:    t = BACK_PACK;
      CODE_AUTO:    t = BACK_AUTO;
      CODE_4X5:     t = BACK_4X5;
      CODE_6X7:     t = BACK_6X7;
      CODE_GENERIC: t = BACK_GENERIC;
      CODE_RSVD_A:  t = BACK_RESERVED;
      CODE_RSVD_B:  t = BACK_RESERVED;
      default:      t = BACK_35MM;
    endcase
    return t;
  endfunction

  // ==========================================================
  // filter bank
  // ==========================================================
  // latency from pin to status: two synchroniser flops, the settle
  // window and one status flop, 253 cycles in all
  // shorter glitches never reach the status outputs
  // settle filtered inputs
  assign dbi.raw = st_r.sync2;

  debounce_bank u_debounce (
    .clk    (clk),
    .arst_n (arst_n),
    .dbi    (dbi)
  );

  // ==========================================================
  // next state
  // ==========================================================
  // everything below except the first synchroniser stage reads registered
  // state and settled levels, so no path runs from a pin to an output
  always_comb begin
    logic [CODE_W-1:0] code_now;
    code_now = '0;
    st_nxt   = st_r;

    // trade-off: every input pays the same settle delay, the sync
    // contact included, so exposure timing is coarse by that much
    // two-flop synchronisers; second stage feeds the filters only
    st_nxt.sync1 = {film_code_bit4, film_code_bit3, film_code_bit2, film_code_bit1,
                    film_code_bit0, back_power_sense, perf_sense_in, sync_contact_in,
                    door_switch_in};
    st_nxt.sync2 = st_r.sync1;

    // settled status; the door switch pulls low when closed
    // a missing back reads as an open door
    // door switch level
    st_nxt.door  = ~dbi.stable[IN_DOOR];
    st_nxt.syncl = dbi.stable[IN_SYNC];
    // the perforation status is masked while perf_enable is low,
    // since the sensor has nothing to see then
    // sensor read only while perf_enable is set
    st_nxt.perf  = perf_enable & dbi.stable[IN_PERF];
    // back power sense is its own input, not a code bit
    st_nxt.pwr   = dbi.stable[IN_PWR];
    // five bits form the code, bit4 most significant
    code_now     = dbi.stable[IN_CODE0 +: CODE_W];
    st_nxt.code  = code_now;
    st_nxt.btype = decode_back(code_now);

    // several code bits settling in one cycle give a single pulse;
    // bits settling apart give one pulse each
    // one-cycle change events
    st_nxt.ev_door = dbi.change[IN_DOOR];
    st_nxt.ev_perf = perf_enable & dbi.change[IN_PERF];
    st_nxt.ev_code = |dbi.change[IN_CODE0 +: CODE_W];
    st_nxt.ev_pwr  = dbi.change[IN_PWR];

    // firmware must pass through off before reversing; the bridge
    // itself inserts no dead time
    // complementary bridge halves; off brakes both low
    case (motor_cmd)
      MOTOR_WIND: begin
        st_nxt.wind_neg = 1'b0;
        st_nxt.wind_pos = 1'b1;
      end
      MOTOR_REWIND: begin
        st_nxt.wind_neg = 1'b1;
        st_nxt.wind_pos = 1'b0;
      end
      default: begin
        st_nxt.wind_neg = 1'b0;
        st_nxt.wind_pos = 1'b0;
      end
    endcase

    // the type used here is last cycle's, so the emitter follows
    // a type change one cycle late
    // emitter lit only with a 35mm back attached
    st_nxt.led_a = perf_enable & (st_r.btype == BACK_35MM);
    st_nxt.led_k = 1'b0;

    // shutter sequencer: actuation low, then release high with sync
    // a close request wins over everything and floats the hold line
    case (st_r.sh)
      SH_IDLE: begin
        // an open with a close in the same cycle is ignored
        if (shutter_open_req && !shutter_close_req) begin
          st_nxt.actuate = 1'b0;
          st_nxt.sh      = SH_PULSE_LOW;
        end
      end
      SH_PULSE_LOW: begin
        // one cycle for the back to see the falling edge
        st_nxt.sh = SH_WAIT_SYNC_LOW;
      end
      SH_WAIT_SYNC_LOW: begin
        // no time limit: a back that never closes the contact leaves
        // the sequence here until firmware closes
        // sync falls: shutter has fired
        if (!dbi.stable[IN_SYNC]) begin
          st_nxt.actuate = 1'b1;
          st_nxt.hold_oe = 1'b1;
          st_nxt.sh      = SH_WAIT_SYNC_HIGH;
        end
      end
      SH_WAIT_SYNC_HIGH: begin
        // contact reopening ends the exposure window
        if (dbi.stable[IN_SYNC]) begin
          st_nxt.sh = SH_HOLD;
        end
      end
      SH_HOLD: begin
        // waits here for firmware to close
      end
      default: begin
        // unused state codes fall back to rest
        st_nxt.sh = SH_IDLE;
      end
    endcase
    if (shutter_close_req) begin
      // close also recovers a sequence stuck waiting for the contact
      // release hold line to float
      st_nxt.hold_oe = 1'b0;
      st_nxt.actuate = 1'b1;
      st_nxt.sh      = SH_IDLE;
    end
    st_nxt.busy = (st_nxt.sh != SH_IDLE);
  end

  // ==========================================================
  // state register
  // ==========================================================
  // inputs idle at their pull levels after reset
  // the asynchronous branch loads constants only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r         <= '0;
      st_r.actuate <= 1'b1;
      st_r.sync1   <= IN_IDLE;
      st_r.sync2   <= IN_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs, each straight from a flop except the constant hold pin value
  // ==========================================================
  // the hold pin is open drain: its value is always low and only
  // the enable moves, so the shutter closes on a floating line
  // busy is registered with the state, so it agrees with the
  // sequencer in every cycle
  assign shutter_hold_drive    = 1'b0;
  assign shutter_hold_oe       = st_r.hold_oe;
  assign shutter_actuate_drive = st_r.actuate;
  assign film_wind_neg         = st_r.wind_neg;
  assign film_wind_pos         = st_r.wind_pos;
  assign perf_emitter_anode    = st_r.led_a;
  assign perf_emitter_cathode  = st_r.led_k;
  assign door_closed           = st_r.door;
  assign sync_level            = st_r.syncl;
  assign perf_seen             = st_r.perf;
  assign back_power_ok         = st_r.pwr;
  assign film_code             = st_r.code;
  assign back_type             = st_r.btype;
  assign shutter_busy          = st_r.busy;
  assign door_event            = st_r.ev_door;
  assign perf_event            = st_r.ev_perf;
  assign code_event            = st_r.ev_code;
  assign power_event           = st_r.ev_pwr;
endmodule

// File: tb/cam_back_model.sv
`timescale 1ns/1ns
// ==========================================================
// attached camera back: sync contact and perforation sensor
// ==========================================================
module cam_back_model #(
  parameter int DLY = 5,    // cycles from actuation to contact closing
  parameter int LOW = 300   // cycles the contact stays closed
) (
  // clock
  input  wire logic clk,
  // from the recorder
  input  wire logic shutter_actuate_drive,
  input  wire logic perf_emitter_anode,
  // film position set by the bench
  input  wire logic hole,
  // to the recorder
  output logic      sync_contact_in,
  output logic      perf_sense_in
);
  // pull-up holds the contact high between exposures
  initial sync_contact_in = 1'b1;
  // contact timing
  // closes a few cycles after actuation and stays long enough to settle
  always begin
    @(negedge shutter_actuate_drive);
    repeat (DLY) @(posedge clk);
    #1 sync_contact_in = 1'b0;
    repeat (LOW) @(posedge clk);
    #1 sync_contact_in = 1'b1;
  end
  // sensor sees light only through a perforation
  assign perf_sense_in = perf_emitter_anode & hole;
endmodule

// File: tb/camera_back_interface_chk.sv
`timescale 1ns/1ns
// ==========================================================
// port checker
// ==========================================================
module camera_back_interface_chk
  import cam_back_pkg::*;
(
  // clock and reset
  input wire logic                     clk,
  input wire logic                     arst_n,
  // controls
  input wire logic                     shutter_open_req,
  input wire logic                     shutter_close_req,
  input wire cam_back_pkg::motor_cmd_t motor_cmd,
  input wire logic                     perf_enable,
  // outputs watched
  input wire logic                     shutter_hold_drive,
  input wire logic                     shutter_hold_oe,
  input wire logic                     shutter_actuate_drive,
  input wire logic                     film_wind_neg,
  input wire logic                     film_wind_pos,
  input wire logic                     perf_emitter_anode,
  input wire logic                     perf_emitter_cathode,
  input wire logic                     back_power_ok,
  input wire logic [CODE_W-1:0]        film_code,
  input wire cam_back_pkg::back_type_t back_type,
  input wire logic                     shutter_busy,
  input wire logic                     code_event,
  input wire logic                     power_event
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // expected type of a settled code; unlisted codes are film speeds
  function automatic back_type_t dec(logic [4:0] c);
    case (c)
      CODE_PACK:                return BACK_PACK;
      CODE_AUTO:                return BACK_AUTO;
      CODE_4X5:                 return BACK_4X5;
      CODE_6X7:                 return BACK_6X7;
      CODE_RSVD_A, CODE_RSVD_B: return BACK_RESERVED;
      CODE_GENERIC:             return BACK_GENERIC;
      default:                  return BACK_35MM;
    endcase
  endfunction
  a_hold_pin_low: assert property (shutter_hold_drive == 1'b0)
    else $error("hold pin value not low");
  a_close_release: assert property (shutter_close_req |=> !shutter_hold_oe && !shutter_busy)
    else $error("close did not release hold");
  a_open_start: assert property (shutter_open_req && !shutter_close_req && !shutter_busy
    |=> !shutter_actuate_drive && shutter_busy) else $error("open did not start actuation");
  a_actuate_end: assert property ($rose(shutter_actuate_drive) && !$past(shutter_close_req)
    |-> shutter_hold_oe) else $error("actuation ended without hold");
  a_wind_dir: assert property (motor_cmd == MOTOR_WIND |=> !film_wind_neg && film_wind_pos)
    else $error("wind direction wrong");
  a_rewind_dir: assert property (motor_cmd == MOTOR_REWIND |=> film_wind_neg && !film_wind_pos)
    else $error("rewind direction wrong");
  a_emit_on: assert property (perf_enable && back_type == BACK_35MM |=> perf_emitter_anode)
    else $error("emitter not lit");
  a_emit_off: assert property (!perf_enable || back_type != BACK_35MM
    |=> !perf_emitter_anode && !perf_emitter_cathode) else $error("emitter lit wrongly");
  a_code_type: assert property ($stable(film_code) |-> back_type == dec(film_code))
    else $error("back type does not match code");
  a_code_event: assert property ($changed(film_code) |-> code_event)
    else $error("code change without event");
  a_power_event: assert property ($changed(back_power_ok) |-> power_event)
    else $error("power change without event");
  // power bit kept out of the code
  a_power_apart: assert property (power_event |-> $stable(film_code))
    else $error("power sense moved the code");
endmodule
bind camera_back_interface camera_back_interface_chk chk (.*);

// File: tb/camera_back_interface_test.sv
`timescale 1ns/1ns
// ==========================================================
// self-checking bench
// ==========================================================
module camera_back_interface_test;
  import cam_back_pkg::*;
  // stimulus
  logic       clk = 0, arst_n = 0, shutter_open_req = 0, shutter_close_req = 0, perf_enable = 0;
  logic       door_switch_in = 1, back_power_sense = 0, hole = 0;
  logic [4:0] code = 5'h00;
  motor_cmd_t motor_cmd = MOTOR_OFF;
  // observed
  logic       sync_contact_in, perf_sense_in, shutter_hold_drive, shutter_hold_oe, shutter_actuate_drive;
  logic       film_wind_neg, film_wind_pos, perf_emitter_anode, perf_emitter_cathode, door_closed;
  logic       sync_level, perf_seen, back_power_ok, shutter_busy, door_event, perf_event;
  logic       code_event, power_event;
  logic [4:0] film_code;
  back_type_t back_type;
  int         failures = 0, samples_checked = 0, n;
  int         door_pulses = 0, perf_pulses = 0;
  // event pulses counted on the falling edge, where they are settled
  always @(negedge clk) begin
    door_pulses += int'(door_event);
    perf_pulses += int'(perf_event);
  end
  // code table walked by the decode scenario, ending on a film speed
  logic [4:0] cv [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h12};
  back_type_t tv [9] = '{BACK_35MM, BACK_PACK, BACK_AUTO, BACK_4X5, BACK_6X7, BACK_RESERVED,
                         BACK_RESERVED, BACK_GENERIC, BACK_35MM};
  always #2 clk = ~clk;
  // design, with the code bits split onto their pins
  camera_back_interface dut (.*, .film_code_bit0(code[0]), .film_code_bit1(code[1]),
    .film_code_bit2(code[2]), .film_code_bit3(code[3]), .film_code_bit4(code[4]));
  cam_back_model back (.clk(clk), .shutter_actuate_drive(shutter_actuate_drive),
    .perf_emitter_anode(perf_emitter_anode), .hole(hole), .sync_contact_in(sync_contact_in),
    .perf_sense_in(perf_sense_in));
  // step past n edges, landing just after the last
  task tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task check(string what, logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task report_and_stop;
    if (failures == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // outputs while reset is held
  task t_reset;
    check("actuate", 8'h01, 8'(shutter_actuate_drive));
    check("hold_oe", 8'h00, 8'(shutter_hold_oe));
  endtask
  // every motor command
  task t_motor;
    for (int i = 0; i < 3; i++) begin
      motor_cmd = motor_cmd_t'(i);
      tick(2);
      check("bridge", 8'(i), 8'({film_wind_neg, film_wind_pos}));
    end
  endtask
  // power bit first, then every listed code and a film speed
  task t_codes;
    back_power_sense = 1;
    tick(270);
    check("power_ok", 8'h01, 8'(back_power_ok));
    check("code_pwr", 8'h00, 8'(film_code));
    for (int i = 0; i < 9; i++) begin
      code = cv[i];
      tick(270);
      check("film_code", 8'(cv[i]), 8'(film_code));
      check("back_type", 8'(tv[i]), 8'(back_type));
    end
  endtask
  // short glitch refused, then a real closing; emitter and sensor
  task t_door_perf;
    int d0, q0;
    d0 = door_pulses;
    door_switch_in = 0;
    tick(100);
    door_switch_in = 1;
    tick(270);
    check("door_glitch", 8'h00, 8'(door_closed));
    check("door_glitch_ev", 8'h00, 8'(door_pulses - d0));
    door_switch_in = 0;
    tick(270);
    check("door", 8'h01, 8'(door_closed));
    check("door_ev", 8'h01, 8'(door_pulses - d0));
    perf_enable = 1;
    tick(2);
    check("anode", 8'h01, 8'(perf_emitter_anode));
    check("perf_dark", 8'h00, 8'(perf_seen));
    q0 = perf_pulses;
    hole = 1;
    tick(270);
    check("perf_seen", 8'h01, 8'(perf_seen));
    check("perf_ev", 8'h01, 8'(perf_pulses - q0));
    code = CODE_PACK;
    tick(272);
    check("anode_off", 8'h00, 8'(perf_emitter_anode));
  endtask
  // open against the contact, refuse a second open, then close
  task t_shutter;
    shutter_open_req = 1;
    tick(1);
    shutter_open_req = 0;
    check("act_low", 8'h00, 8'(shutter_actuate_drive));
    for (n = 0; n < 400 && shutter_hold_oe !== 1'b1; n++) tick(1);
    check("hold_open", 8'h01, 8'(shutter_hold_oe));
    check("act_high", 8'h01, 8'(shutter_actuate_drive));
    check("waited_sync", 8'h01, 8'(n > 200));
    check("sync_low", 8'h00, 8'(sync_level));
    tick(400);
    check("sync_high", 8'h01, 8'(sync_level));
    shutter_open_req = 1;
    tick(1);
    shutter_open_req = 0;
    check("act_refused", 8'h01, 8'(shutter_actuate_drive));
    shutter_close_req = 1;
    tick(1);
    shutter_close_req = 0;
    check("hold_float", 8'h00, 8'(shutter_hold_oe));
    check("busy", 8'h00, 8'(shutter_busy));
  endtask
  // reset in mid-sequence drops the shutter back to rest
  task t_midreset;
    shutter_open_req = 1;
    tick(1);
    shutter_open_req = 0;
    check("mid_busy", 8'h01, 8'(shutter_busy));
    arst_n = 0;
    #1;
    t_reset;
    tick(2);
    arst_n = 1;
    tick(2);
    check("mid_act", 8'h01, 8'(shutter_actuate_drive));
    check("mid_idle", 8'h00, 8'(shutter_busy));
  endtask
  // main sequence
  initial begin
    tick(1);
    t_reset;
    tick(1);
    arst_n = 1;
    t_motor;
    t_codes;
    t_door_perf;
    t_shutter;
    t_midreset;
    report_and_stop;
  end
  // watchdog, about five times the expected run
  initial begin
    #100000;
    failures++;
    report_and_stop;
  end
endmodule
